// ==== dv/fsc_fan_model.sv ====
/*
  fsc_fan_model: 4-wire fan behind the pwm pin and tach measurement.
  assumes a pull-up on the pwm pin and a bench that commands stall and speed.
*/
`timescale 1ns/1ns
module fsc_fan_model (
  input  wire logic        clk,        // system clock
  input  wire logic        pwm_o,      // pin level from dut
  input  wire logic        pwm_oe_n,   // pin enable, low drives
  input  wire logic        stall,      // rotor stuck
  input  wire logic [7:0]  speed,      // healthy tach count
  input  wire logic        clear,      // restart duty counters
  output logic      [7:0]  tach_count, // measured count
  output logic      [15:0] pin_high,   // cycles pin high
  output logic      [15:0] oe_high     // cycles pin released
);
  logic pin;
  assign pin = pwm_oe_n ? 1'b1 : pwm_o;
  assign tach_count = stall ? 8'hF0 : speed;
  always_ff @(posedge clk)
  begin
    pin_high <= clear ? 16'h0000 : pin_high + 16'(pin);
    oe_high  <= clear ? 16'h0000 : oe_high + 16'(pwm_oe_n);
  end
endmodule

// ==== dv/fsc_fan_sva.sv ====
/*
  fsc_fan_sva: port-level assertions for one fan channel.
  assumes it is bound onto fsc_fan_ctrl and sees only one clock domain.
*/
`timescale 1ns/1ns
module fsc_fan_sva (
  input wire logic       clk,               // clock
  input wire logic       rst,               // reset
  input wire logic       loop_enable,       // loop mode
  input wire logic       ramp_limit_enable, // direct ramp
  input wire logic       push_pull,         // pin style
  input wire logic       invert_polarity,   // polarity
  input wire logic [7:0] min_drive,         // loop floor
  input wire logic [7:0] target_count,      // target
  input wire logic [7:0] drive_wdata,       // write data
  input wire logic       drive_wr,          // write strobe
  input wire logic [7:0] drive_setting,     // read-back
  input wire logic       pwm_o,             // pwm level
  input wire logic       pwm_oe_n,          // pwm enable
  input wire logic       alert_o,           // alert level
  input wire logic       alert_oe_n,        // alert enable
  input wire logic       stalled            // stall flag
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_write_taken: assert property (!loop_enable && drive_wr |=> loop_enable ||
    drive_setting == $past(drive_wdata)) else $error("drive write not taken");
  a_push_pull: assert property (push_pull [*2] |-> !pwm_oe_n)
    else $error("push-pull pin released");
  a_open_drain: assert property ((!push_pull) [*2] |-> pwm_oe_n == pwm_o)
    else $error("open drain drives high");
  a_target_off: assert property ((loop_enable && target_count == 8'hFF) [*4]
    |-> drive_setting == 8'h00) else $error("off target leaves drive on");
  a_min_floor: assert property ((loop_enable && target_count != 8'hFF) [*3]
    ##0 $changed(drive_setting) |-> drive_setting >= min_drive) else $error("drive below floor");
  a_stall_alert: assert property ($rose(stalled) |-> ##[0:1] !alert_oe_n)
    else $error("stall without alert");
  a_stall_spin: assert property ($rose(stalled) |-> ##[0:2] drive_setting == 8'hFF)
    else $error("stall without spin-up drive");
  a_alert_level: assert property (!alert_o)
    else $error("alert pin driven high");
  a_duty_zero: assert property ((!loop_enable && !ramp_limit_enable &&
    drive_setting == 8'h00 && $stable(invert_polarity)) [*3] |-> pwm_o == invert_polarity)
    else $error("zero drive not idle");
  a_duty_full: assert property ((!loop_enable && !ramp_limit_enable &&
    drive_setting == 8'hFF && $stable(invert_polarity)) [*3] |-> pwm_o != invert_polarity)
    else $error("full drive not active");

  c_stall: cover property ($rose(stalled));
  c_off: cover property (loop_enable && target_count == 8'hFF && drive_setting == 8'h00);
  c_write: cover property (!loop_enable && drive_wr);
endmodule

bind fsc_fan_ctrl fsc_fan_sva i_sva (.clk, .rst, .loop_enable, .ramp_limit_enable,
  .push_pull, .invert_polarity, .min_drive, .target_count, .drive_wdata, .drive_wr,
  .drive_setting, .pwm_o, .pwm_oe_n, .alert_o, .alert_oe_n, .stalled);

// ==== dv/testbench.sv ====
/*
  testbench: reset, table-driven pwm checks, then stall and loop cases.
  assumes fsc_fan_ctrl, fsc_pkg and the fan model are compiled before it.
*/
`timescale 1ns/1ns
module testbench;
  typedef struct {logic [1:0] b; logic [7:0] dv; logic [7:0] dr; logic inv; logic pp;} fsc_row_t;
  fsc_row_t rows [5] = '{'{2'h0, 8'h01, 8'h00, 1'h0, 1'h0}, '{2'h0, 8'h00, 8'h80, 1'h0, 1'h1},
    '{2'h1, 8'h01, 8'hFF, 1'h1, 1'h1}, '{2'h1, 8'h00, 8'h40, 1'h1, 1'h0},
    '{2'h0, 8'h02, 8'h01, 1'h0, 1'h1}};
  logic        clk = 0, rst = 1, ref_clk_in = 0, loop_enable = 0, push_pull = 0;
  logic        invert_polarity = 0, drive_wr = 0, alert_clear = 0, stall = 1, clear = 0;
  logic        ramp_limit_enable = 0;
  logic [1:0]  base_select = 2'h0, error_band_select = 2'h0, integral_gain = 2'h2;
  logic [2:0]  update_period_bits = 3'h0;
  logic [7:0]  freq_divide = 8'h01, min_drive = 8'h00, valid_count = 8'hFF;
  logic [7:0]  target_count = 8'hFF, drive_wdata = 8'h00, tach_count, drive_setting;
  logic        pwm_o, pwm_oe_n, alert_o, alert_oe_n, stalled;
  logic [15:0] pin_high, oe_high;
  int          n_fail = 0, n_compared = 0, st, d, hi;

  initial forever #4 clk = ~clk;
  initial forever #17 ref_clk_in = ~ref_clk_in;

  fsc_fan_ctrl #(.SPIN_REF_TICKS(4)) i_dut (.clk, .rst, .ref_clk_in, .loop_enable,
    .ramp_limit_enable, .base_select, .freq_divide, .push_pull, .invert_polarity,
    .update_period_bits, .error_band_select, .derivative_option(fsc_pkg::DEF_DERIVATIVE),
    .proportional_gain(fsc_pkg::DEF_GAIN), .integral_gain, .derivative_gain(fsc_pkg::DEF_GAIN),
    .max_step(8'h08), .min_drive, .valid_count, .target_count, .tach_count, .drive_wdata,
    .drive_wr, .alert_clear, .drive_setting, .pwm_o, .pwm_oe_n, .alert_o, .alert_oe_n, .stalled);
  fsc_fan_model i_fan (.clk, .pwm_o, .pwm_oe_n, .stall, .speed(8'h36), .clear, .tach_count,
    .pin_high, .oe_high);

  task automatic close_out;
    $display("compared %0d, wrong %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: %0s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic check_count(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: %0s got %0d exp %0d", $time, what, got, exp);
    end
  endtask

  task automatic write_drive(input logic [7:0] v);
    @(posedge clk);
    drive_wdata <= v;
    drive_wr <= 1'b1;
    @(posedge clk);
    drive_wr <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  // restart the fan model counters, then count n cycles of the pin
  task automatic pwm_window(input int n);
    @(posedge clk);
    clear <= 1'b1;
    @(posedge clk);
    clear <= 1'b0;
    repeat (n) @(posedge clk);
    #1;
  endtask

  initial
  begin
    repeat (95000) @(posedge clk);
    n_fail++;
    close_out();
  end

  initial
  begin
    repeat (19) @(posedge clk);
    #1;
    check_byte(drive_setting, 8'h00, "reset drive");
    check_byte({7'h00, alert_oe_n, stalled}, 8'h02, "reset alert");
    @(posedge clk);
    rst <= 1'b0;
    $display("test reset done");
    for (int r = 0; r < 5; r++)
    begin
      @(posedge clk);
      base_select <= rows[r].b;
      freq_divide <= rows[r].dv;
      invert_polarity <= rows[r].inv;
      push_pull <= rows[r].pp;
      write_drive(rows[r].dr);
      check_byte(drive_setting, rows[r].dr, "drive readback");
      repeat (512) @(posedge clk);
      clear <= 1'b1;
      @(posedge clk);
      clear <= 1'b0;
      st = (rows[r].b == 2'h0) ? int'(fsc_pkg::STEP_CYC_0) : int'(fsc_pkg::STEP_CYC_1);
      d = (rows[r].dv < 8'h02) ? 1 : int'(rows[r].dv);
      hi = (rows[r].inv ? 255 - int'(rows[r].dr) : int'(rows[r].dr)) * st * d;
      repeat (255 * st * d) @(posedge clk);
      #1;
      check_count(pin_high, 16'(hi), "pin high time");
      check_count(oe_high, rows[r].pp ? 16'h0000 : 16'(hi), "pin released");
      $display("test pwm row %0d done", r);
    end
    @(posedge clk);
    error_band_select <= 2'h1;
    integral_gain <= 2'h0;
    min_drive <= 8'hFA;
    valid_count <= 8'h80;
    @(posedge clk);
    target_count <= 8'h40;
    @(posedge clk);
    loop_enable <= 1'b1;
    for (int i = 0; i < 16000 && stalled !== 1'b1; i++) @(posedge clk);
    repeat (2) @(posedge clk);
    check_byte({7'h00, alert_oe_n}, 8'h00, "stall alert");
    check_byte(drive_setting, fsc_pkg::DRIVE_FULL, "spin-up drive");
    stall <= 1'b0;
    alert_clear <= 1'b1;
    @(posedge clk);
    alert_clear <= 1'b0;
    repeat (2) @(posedge clk);
    check_byte({7'h00, alert_oe_n}, 8'h01, "alert cleared");
    for (int i = 0; i < 20000 && drive_setting === 8'hFF; i++) @(posedge clk);
    repeat (2) @(posedge clk);
    check_byte(drive_setting, 8'hFA, "loop floor");
    check_byte({7'h00, stalled}, 8'h00, "fan healthy");
    $display("test stall done");
    target_count <= fsc_pkg::TARGET_OFF;
    repeat (6) @(posedge clk);
    check_byte(drive_setting, fsc_pkg::DRIVE_ZERO, "target off");
    write_drive(8'h55);
    check_byte(drive_setting, 8'h00, "loop write refused");
    loop_enable <= 1'b0;
    repeat (3) @(posedge clk);
    check_byte(drive_setting, 8'h01, "direct setting back");
    $display("test loop off done");
    // mid-run reset aligns the update timer for the direct ramp case
    rst <= 1'b1;
    ramp_limit_enable <= 1'b1;
    freq_divide <= 8'h01;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    check_byte(drive_setting, 8'h00, "mid-run reset");
    write_drive(8'h21);
    check_byte(drive_setting, 8'h21, "ramp setting");
    st = int'(fsc_pkg::STEP_CYC_0);
    pwm_window(255 * st);
    check_count(pin_high, 16'h0000, "ramp before update");
    @(posedge clk);
    repeat (10000) @(posedge clk);
    pwm_window(255 * st);
    check_count(pin_high, 16'(8 * st), "ramp one step");
    @(posedge clk);
    $display("test direct ramp done");
    close_out();
  end
endmodule

// ==== logic/fsc_fan_ctrl.sv ====
/*
  fsc_fan_ctrl: one fan channel - pwm generator, direct drive mode and
  closed-loop pid speed control on tach counts.
  assumes tach_count comes from a tach measurement block on clk and
  ref_clk_in is an asynchronous 32.768 kHz reference from a pin.
*/
`timescale 1ns/1ns
module fsc_fan_ctrl #(
  parameter int SPIN_REF_TICKS = 16384  // spin-up time in reference ticks
) (
  input  wire logic       clk,               // system clock, 125 MHz
  input  wire logic       rst,               // async reset, active high
  input  wire logic       ref_clk_in,        // 32.768 kHz reference pin
  input  wire logic       loop_enable,       // closed-loop speed mode
  input  wire logic       ramp_limit_enable, // ramp limit in direct mode
  input  wire logic [1:0] base_select,       // pwm base frequency
  input  wire logic [7:0] freq_divide,       // pwm frequency divider
  input  wire logic       push_pull,         // 1 push-pull, 0 open drain
  input  wire logic       invert_polarity,   // invert pwm output
  input  wire logic [2:0] update_period_bits,// update period select
  input  wire logic [1:0] error_band_select, // error band select
  input  wire logic [1:0] derivative_option, // derivative handling
  input  wire logic [1:0] proportional_gain, // p gain
  input  wire logic [1:0] integral_gain,     // i gain
  input  wire logic [1:0] derivative_gain,   // d gain
  input  wire logic [7:0] max_step,          // largest drive step, except loop steps with DER_STEP or DER_BOTH
  input  wire logic [7:0] min_drive,         // loop minimum drive
  input  wire logic [7:0] valid_count,       // highest healthy tach count
  input  wire logic [7:0] target_count,      // tach target
  input  wire logic [7:0] tach_count,        // measured tach count
  input  wire logic [7:0] drive_wdata,       // drive setting write data
  input  wire logic       drive_wr,          // drive setting write strobe
  input  wire logic       alert_clear,       // clears stall alert
  output logic      [7:0] drive_setting,     // drive setting read-back
  output logic            pwm_o,             // pwm pin output level
  output logic            pwm_oe_n,          // pwm pin enable, low drives
  output logic            alert_o,           // alert pin output level
  output logic            alert_oe_n,        // alert pin enable, low drives
  output logic            stalled            // stall seen at last update
);

  initial
  begin
    if (SPIN_REF_TICKS < 1 || SPIN_REF_TICKS > 65535)
    begin
      $error("SPIN_REF_TICKS out of range");
    end
  end

  typedef struct packed {
    logic [1:0]        ref_sync;
    logic              ref_prev;
    fsc_pkg::fsc_state_t st;
    logic [15:0]       upd_cnt;
    logic [15:0]       spin_cnt;
    logic [7:0]        base_cnt;
    logic [7:0]        div_cnt;
    logic [7:0]        pwm_cnt;
    logic [7:0]        drive;
    logic [7:0]        drive_set;
    logic signed [17:0] integ;
    logic signed [9:0] err_prev;
    logic              alert;
    logic              stalled;
    logic [7:0]        readback;
    logic              pwm_o;
    logic              pwm_oe_n;
  } fsc_reg_t;

  fsc_reg_t r_q;
  fsc_reg_t r_d;

  function automatic logic signed [17:0] gain_apply(input logic signed [17:0] v,
                                                     input logic [1:0] g);
    gain_apply = v <<< g;
  endfunction

  function automatic logic signed [17:0] clamp_s(input logic signed [17:0] v,
                                                  input logic signed [17:0] lo,
                                                  input logic signed [17:0] hi);
    if (v < lo)
    begin
      clamp_s = lo;
    end
    else if (v > hi)
    begin
      clamp_s = hi;
    end
    else
    begin
      clamp_s = v;
    end
  endfunction

  // one ramp step from cur toward req, at most stp
  function automatic logic [7:0] ramp_to(input logic [7:0] cur,
                                         input logic [7:0] req,
                                         input logic [7:0] stp);
    logic signed [17:0] dlt;
    dlt = 18'(signed'({1'b0, req})) - 18'(signed'({1'b0, cur}));
    dlt = clamp_s(dlt, -18'(signed'({1'b0, stp})), 18'(signed'({1'b0, stp})));
    ramp_to = 8'(18'(signed'({1'b0, cur})) + dlt);
  endfunction

  logic [7:0]  step_cyc;
  logic [7:0]  div_lim;
  logic [15:0] upd_lim;
  logic [7:0]  band_rpm;
  logic [7:0]  band;
  logic [23:0] band_prod;
  logic        ref_tick;

  always_comb
  begin
    case (base_select)
      2'b00:   step_cyc = fsc_pkg::STEP_CYC_0;
      2'b01:   step_cyc = fsc_pkg::STEP_CYC_1;
      2'b10:   step_cyc = fsc_pkg::STEP_CYC_2;
      default: step_cyc = fsc_pkg::STEP_CYC_3;
    endcase
    // zero divides like one
    div_lim = (freq_divide == 8'h00) ? 8'h01 : freq_divide;
    case (update_period_bits)
      3'b000:  upd_lim = fsc_pkg::UPD_TK_0;
      3'b001:  upd_lim = fsc_pkg::UPD_TK_1;
      3'b010:  upd_lim = fsc_pkg::UPD_TK_2;
      3'b011:  upd_lim = fsc_pkg::UPD_TK_3;
      3'b100:  upd_lim = fsc_pkg::UPD_TK_4;
      3'b101:  upd_lim = fsc_pkg::UPD_TK_5;
      3'b110:  upd_lim = fsc_pkg::UPD_TK_6;
      default: upd_lim = fsc_pkg::UPD_TK_7;
    endcase
    case (error_band_select)
      2'b00:   band_rpm = fsc_pkg::BAND_RPM_0;
      2'b01:   band_rpm = fsc_pkg::BAND_RPM_1;
      2'b10:   band_rpm = fsc_pkg::BAND_RPM_2;
      default: band_rpm = fsc_pkg::BAND_RPM_3;
    endcase
    // rpm band to counts: dcount ~ count^2 * drpm / k
    band_prod = (24'(target_count) * 24'(target_count) * 24'(band_rpm)) / fsc_pkg::TACH_RPM_K;
    band = 8'(band_prod);
  end

  // rising edge of the synchronised reference
  assign ref_tick = r_q.ref_sync[1] & ~r_q.ref_prev;

  logic              upd_tick;
  logic signed [9:0] err;
  logic [9:0]        err_abs;
  logic signed [17:0] p_term;
  logic signed [17:0] i_term;
  logic signed [17:0] d_term;
  logic signed [17:0] lim_sum;
  logic signed [17:0] step_v;
  logic signed [17:0] new_drv;
  logic [7:0]        floor_drv;

  always_comb
  begin
    r_d = r_q;
    r_d.ref_sync = {r_q.ref_sync[0], ref_clk_in};
    r_d.ref_prev = r_q.ref_sync[1];

    // update period timer on reference ticks
    upd_tick = 1'b0;
    if (ref_tick)
    begin
      if (r_q.upd_cnt >= upd_lim - 16'h0001)
      begin
        r_d.upd_cnt = 16'h0000;
        upd_tick = 1'b1;
      end
      else
      begin
        r_d.upd_cnt = r_q.upd_cnt + 16'h0001;
      end
    end

    // pid terms on tach count error; positive means too slow
    err = 10'(signed'({2'b00, tach_count})) - 10'(signed'({2'b00, target_count}));
    err_abs = err[9] ? 10'(-err) : 10'(err);
    p_term = gain_apply(18'(err), proportional_gain);
    i_term = gain_apply(r_q.integ >>> fsc_pkg::INTEG_SHIFT, integral_gain);
    d_term = gain_apply(18'(err) - 18'(r_q.err_prev), derivative_gain);
    lim_sum = p_term + i_term;
    if (derivative_option != fsc_pkg::DER_NONE)
    begin
      lim_sum = lim_sum + d_term;
    end
    lim_sum = lim_sum >>> fsc_pkg::SUM_SHIFT;
    if (derivative_option == fsc_pkg::DER_STEP)
    begin
      step_v = lim_sum;
    end
    else
    begin
      step_v = clamp_s(lim_sum, -18'(signed'({1'b0, max_step})),
                       18'(signed'({1'b0, max_step})));
    end
    if (derivative_option == fsc_pkg::DER_BOTH)
    begin
      step_v = step_v + (d_term >>> fsc_pkg::SUM_SHIFT);
    end
    floor_drv = min_drive;
    new_drv = clamp_s(18'(signed'({1'b0, r_q.drive})) + step_v,
                      18'(signed'({1'b0, floor_drv})),
                      18'(signed'({1'b0, fsc_pkg::DRIVE_FULL})));

    // drive setting register takes writes only in direct mode
    if (drive_wr && !loop_enable)
    begin
      r_d.drive_set = drive_wdata;
    end

    case (r_q.st)
      fsc_pkg::FSC_ST_DIRECT:
      begin
        if (loop_enable)
        begin
          r_d.st = fsc_pkg::FSC_ST_RUN;
          r_d.integ = '0;
          r_d.err_prev = '0;
        end
        else if (!ramp_limit_enable)
        begin
          r_d.drive = r_d.drive_set;
        end
        else if (upd_tick)
        begin
          r_d.drive = ramp_to(r_q.drive, r_q.drive_set, max_step);
        end
      end
      fsc_pkg::FSC_ST_RUN:
      begin
        if (!loop_enable)
        begin
          r_d.st = fsc_pkg::FSC_ST_DIRECT;
        end
        else if (target_count == fsc_pkg::TARGET_OFF)
        begin
          r_d.drive = fsc_pkg::DRIVE_ZERO;
          r_d.integ = '0;
        end
        else if (upd_tick)
        begin
          r_d.stalled = (tach_count > valid_count);
          if (tach_count > valid_count)
          begin
            r_d.st = fsc_pkg::FSC_ST_SPIN;
            r_d.spin_cnt = 16'h0000;
            r_d.drive = fsc_pkg::DRIVE_FULL;
          end
          else if (err_abs > 10'(band))
          begin
            r_d.integ = clamp_s(r_q.integ + 18'(err), -18'sh0FFFF, 18'sh0FFFF);
            r_d.err_prev = err;
            r_d.drive = 8'(new_drv);
          end
          else
          begin
            r_d.err_prev = err;
          end
        end
      end
      fsc_pkg::FSC_ST_SPIN:
      begin
        r_d.drive = fsc_pkg::DRIVE_FULL;
        if (!loop_enable)
        begin
          r_d.st = fsc_pkg::FSC_ST_DIRECT;
        end
        else if (target_count == fsc_pkg::TARGET_OFF)
        begin
          r_d.st = fsc_pkg::FSC_ST_RUN;
          r_d.drive = fsc_pkg::DRIVE_ZERO;
        end
        else if (ref_tick)
        begin
          if (r_q.spin_cnt >= 16'(SPIN_REF_TICKS - 1))
          begin
            // retried on the next update if still stalled
            r_d.st = fsc_pkg::FSC_ST_RUN;
            r_d.integ = '0;
          end
          else
          begin
            r_d.spin_cnt = r_q.spin_cnt + 16'h0001;
          end
        end
      end
      default:
      begin
        r_d.st = fsc_pkg::FSC_ST_DIRECT;
      end
    endcase

    // sticky alert, a new stall wins over a clear
    if (alert_clear)
    begin
      r_d.alert = 1'b0;
    end
    if (r_d.st == fsc_pkg::FSC_ST_SPIN && r_q.st == fsc_pkg::FSC_ST_RUN)
    begin
      r_d.alert = 1'b1;
    end

    // loop mode shows computed drive, direct shows stored setting
    r_d.readback = loop_enable ? r_d.drive : r_d.drive_set;

    // pwm step prescaler, divider and 255-step period
    if (r_q.base_cnt >= step_cyc - 8'h01)
    begin
      r_d.base_cnt = 8'h00;
      if (r_q.div_cnt >= div_lim - 8'h01)
      begin
        r_d.div_cnt = 8'h00;
        r_d.pwm_cnt = (r_q.pwm_cnt >= fsc_pkg::PWM_LAST) ? 8'h00 : r_q.pwm_cnt + 8'h01;
      end
      else
      begin
        r_d.div_cnt = r_q.div_cnt + 8'h01;
      end
    end
    else
    begin
      r_d.base_cnt = r_q.base_cnt + 8'h01;
    end
    // high for drive of 255 steps, then polarity, then drive style
    r_d.pwm_o = (r_q.pwm_cnt < r_q.drive) ^ invert_polarity;
    r_d.pwm_oe_n = push_pull ? 1'b0 : r_d.pwm_o;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      r_q <= '{
        ref_sync: 2'b00,
        ref_prev: 1'b0,
        st:       fsc_pkg::FSC_ST_DIRECT,
        upd_cnt:  16'h0000,
        spin_cnt: 16'h0000,
        base_cnt: 8'h00,
        div_cnt:  8'h00,
        pwm_cnt:  8'h00,
        drive:    8'h00,
        drive_set: 8'h00,
        integ:    18'sh00000,
        err_prev: 10'sh000,
        alert:    1'b0,
        stalled:  1'b0,
        readback: 8'h00,
        pwm_o:    1'b0,
        pwm_oe_n: 1'b0
      };
    end
    else
    begin
      r_q <= r_d;
    end
  end

  // outputs from flops, except alert_o tied low and alert_oe_n inverted from the alert flop
  assign drive_setting = r_q.readback;
  assign pwm_o         = r_q.pwm_o;
  assign pwm_oe_n      = r_q.pwm_oe_n;
  assign alert_o       = 1'b0;
  assign alert_oe_n    = ~r_q.alert;
  assign stalled       = r_q.stalled;

endmodule

// ==== logic/fsc_pkg.sv ====
/*
  fsc_pkg: constants and shared types for the pwm fan speed controller.
  assumes a 125 MHz system clock and a 32.768 kHz tach reference pin.
*/
package fsc_pkg;

  // system clock and pwm resolution
  localparam longint CLK_HZ    = 125_000_000;
  localparam longint PWM_STEPS = 255;

  // base frequencies in mHz, selected by the 2-bit base field
  localparam longint BASE_MHZ_0 = 26_000_000;
  localparam longint BASE_MHZ_1 = 19_531_000;
  localparam longint BASE_MHZ_2 = 4_882_000;
  localparam longint BASE_MHZ_3 = 2_441_000;

  // clk cycles per pwm step at each base frequency (rounded down)
  localparam logic [7:0] STEP_CYC_0 = 8'((CLK_HZ * 1000) / (BASE_MHZ_0 * PWM_STEPS));
  localparam logic [7:0] STEP_CYC_1 = 8'((CLK_HZ * 1000) / (BASE_MHZ_1 * PWM_STEPS));
  localparam logic [7:0] STEP_CYC_2 = 8'((CLK_HZ * 1000) / (BASE_MHZ_2 * PWM_STEPS));
  localparam logic [7:0] STEP_CYC_3 = 8'((CLK_HZ * 1000) / (BASE_MHZ_3 * PWM_STEPS));
  localparam logic [7:0] PWM_LAST   = 8'hFE;

  // update period in ms and in reference ticks
  localparam longint REF_HZ   = 32_768;
  localparam longint UPD_MS_0 = 100;
  localparam longint UPD_MS_1 = 200;
  localparam longint UPD_MS_2 = 300;
  localparam longint UPD_MS_3 = 400;
  localparam longint UPD_MS_4 = 500;
  localparam longint UPD_MS_5 = 800;
  localparam longint UPD_MS_6 = 1200;
  localparam longint UPD_MS_7 = 1600;
  localparam logic [15:0] UPD_TK_0 = 16'(UPD_MS_0 * REF_HZ / 1000);
  localparam logic [15:0] UPD_TK_1 = 16'(UPD_MS_1 * REF_HZ / 1000);
  localparam logic [15:0] UPD_TK_2 = 16'(UPD_MS_2 * REF_HZ / 1000);
  localparam logic [15:0] UPD_TK_3 = 16'(UPD_MS_3 * REF_HZ / 1000);
  localparam logic [15:0] UPD_TK_4 = 16'(UPD_MS_4 * REF_HZ / 1000);
  localparam logic [15:0] UPD_TK_5 = 16'(UPD_MS_5 * REF_HZ / 1000);
  localparam logic [15:0] UPD_TK_6 = 16'(UPD_MS_6 * REF_HZ / 1000);
  localparam logic [15:0] UPD_TK_7 = 16'(UPD_MS_7 * REF_HZ / 1000);

  // error band in rpm; counts are the high byte of a 32.768 kHz count
  localparam logic [7:0]  BAND_RPM_0 = 8'h00;
  localparam logic [7:0]  BAND_RPM_1 = 8'h32;
  localparam logic [7:0]  BAND_RPM_2 = 8'h64;
  localparam logic [7:0]  BAND_RPM_3 = 8'hC8;
  localparam logic [23:0] TACH_RPM_K = 24'h01E000;

  // drive and target codes
  localparam logic [7:0] DRIVE_FULL = 8'hFF;
  localparam logic [7:0] DRIVE_ZERO = 8'h00;
  localparam logic [7:0] TARGET_OFF = 8'hFF;

  // derivative options
  localparam logic [1:0] DER_NONE  = 2'b00;
  localparam logic [1:0] DER_BASIC = 2'b01;
  localparam logic [1:0] DER_STEP  = 2'b10;
  localparam logic [1:0] DER_BOTH  = 2'b11;

  // documented reset values of the configuration fields, for the host
  localparam logic [1:0] DEF_BASE       = 2'b00;
  localparam logic [7:0] DEF_DIVIDE     = 8'h01;
  localparam logic [2:0] DEF_UPDATE     = 3'b011;
  localparam logic [1:0] DEF_BAND       = 2'b00;
  localparam logic [1:0] DEF_GAIN       = 2'b10;
  localparam logic [1:0] DEF_DERIVATIVE = DER_STEP;
  localparam logic       DEF_OPEN_DRAIN = 1'b1;

  // pid scaling
  localparam int INTEG_SHIFT = 4;
  localparam int SUM_SHIFT   = 2;

  typedef enum logic [2:0] {
    FSC_ST_DIRECT = 3'b001,
    FSC_ST_SPIN   = 3'b010,
    FSC_ST_RUN    = 3'b100
  } fsc_state_t;

endpackage
